// ===== rtu_fieldbus_slave_port.v
// RTU fieldbus slave port: half-duplex serial link, frame capture, reply pacing and loss monitor.
//
// What this block does
// - Processes at most ten requested registers per ten millisecond slot, rest in later slots.
// - A twenty register read is ready for reply within twenty-two milliseconds of arrival.
// - Jumper caught at power-up picks panel or fieldbus; panel mode keeps fieldbus idle.
// - Node address configurable, default one; integrator keeps addresses unique on the link.
// - Bit rate selectable, default 19.2 kbps; master must use the same rate.
// - Parity and stop bits selectable, default 8 even 1; master uses same format.
// - On communication loss a configurable action is taken, fault by default.
// - Loss monitoring enable and restart sources configurable, default control word and references.
// - Loss declared when monitored traffic absent longer than timeout, default 3.0 seconds.
// - Configurable extra delay before each reply starts, default zero milliseconds.
// - Port answers only when the protocol enable selects RTU; otherwise it stays idle.
// - Changed link settings act only after power-up or a refresh command.
// - Word order setting places 32-bit value words in frame, low word first by default.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "rtu_fieldbus_slave_port_regs.vh"

module rtu_fieldbus_slave_port #(
    parameter DEPTH = 64,
    parameter PTR_W = 6,
    parameter SLOT_CYCLES = `SLOT_CYCLES,
    parameter MS_CYCLES = `MS_CYCLES,
    parameter LOSS_UNIT_CYCLES = `LOSS_UNIT_CYCLES
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [`ADDR_W-1:0] addr,
    input wire [31:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [31:0] rd_data,
    input wire link_rx,
    output reg link_tx,
    output reg link_tx_oe,
    input wire port_select_jumper,
    output reg panel_mode,
    output reg comm_loss,
    output reg comm_fault,
    output reg comm_warn
);
    // Staged settings written by software and active settings used by the link.
    reg [10:0] cfg_stage;
    reg [7:0] node_stage;
    reg [15:0] div_stage;
    reg [7:0] loss_stage;
    reg [7:0] delay_stage;
    reg [10:0] cfg;
    reg [7:0] node_addr;
    reg [15:0] baud_div;
    reg [7:0] loss_time;
    reg [7:0] tx_delay;
    reg [31:0] word32;

    localparam [31:0] DIV_RESET = `BAUD_DIV_RESET;
    reg jmp_s1, jmp_s2, jmp_done;
    reg [1:0] jmp_wait;
    reg rx_s1, rx_s2;

    wire fieldbus_active = cfg[`CFG_RTU_EN] & jmp_done & ~panel_mode;
    wire [1:0] parity = cfg[`CFG_PARITY_HI:`CFG_PARITY_LO];
    wire par_en = (parity != `PARITY_NONE);
    wire [3:0] nbits = 4'h9 + {3'h0, par_en} + {3'h0, cfg[`CFG_TWO_STOP]};
    wire [3:0] char_bits = nbits + 4'h1;
    wire [23:0] char_cyc = {8'h00, baud_div} * {20'h0_0000, char_bits};
    wire [23:0] t35_cyc = (char_cyc << 1) + char_cyc + (char_cyc >> 1);

    wire cmd = wr_en && (addr == `REG_COMMAND);
    wire cmd_refresh = cmd && wr_data[`CMD_REFRESH];
    wire cmd_start = cmd && wr_data[`CMD_START_REPLY];
    wire cmd_clear = cmd && wr_data[`CMD_CLEAR_LOSS];
    wire cmd_drop = cmd && wr_data[`CMD_DROP_FRAME];
    wire [2:0] kick = cmd ? wr_data[`CMD_KICK_HI:`CMD_KICK_LO] : 3'h0;

    // Software register file; active settings load only at reset or refresh.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_stage <= `CONFIG_RESET;
            node_stage <= `NODE_ADDR_RESET;
            div_stage <= DIV_RESET[15:0];
            loss_stage <= `LOSS_TIME_RESET;
            delay_stage <= `TX_DELAY_RESET;
            cfg <= `CONFIG_RESET;
            node_addr <= `NODE_ADDR_RESET;
            baud_div <= DIV_RESET[15:0];
            loss_time <= `LOSS_TIME_RESET;
            tx_delay <= `TX_DELAY_RESET;
            word32 <= 32'h0000_0000;
        end else begin
            if (wr_en) begin
                case (addr)
                    `REG_CONFIG: cfg_stage <= wr_data[10:0];
                    `REG_NODE_ADDR: node_stage <= wr_data[7:0];
                    `REG_BAUD_DIV: div_stage <= wr_data[15:0];
                    `REG_LOSS_TIME: loss_stage <= wr_data[7:0];
                    `REG_TX_DELAY: delay_stage <= wr_data[7:0];
                    `REG_WORD32: word32 <= wr_data;
                    default: ;
                endcase
            end
            if (cmd_refresh) begin
                cfg <= cfg_stage;
                node_addr <= node_stage;
                baud_div <= (div_stage == 16'h0000) ? 16'h0001 : div_stage;
                loss_time <= loss_stage;
                tx_delay <= delay_stage;
            end
        end
    end

    // Jumper and receive line pass two flops; the jumper is caught once after release.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            jmp_s1 <= 1'b0;
            jmp_s2 <= 1'b0;
            jmp_wait <= 2'h0;
            jmp_done <= 1'b0;
            panel_mode <= 1'b0;
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end else begin
            jmp_s1 <= port_select_jumper;
            jmp_s2 <= jmp_s1;
            rx_s1 <= link_rx;
            rx_s2 <= rx_s1;
            if (!jmp_done) begin
                jmp_wait <= jmp_wait + 2'h1;
                if (jmp_wait == 2'h3) begin
                    jmp_done <= 1'b1;
                    panel_mode <= jmp_s2;
                end
            end
        end
    end

    // Time bases; the slot and loss bases run freely, the millisecond base restarts on a start command.
    reg [31:0] slot_cnt, ms_cnt, unit_cnt;
    wire slot_tick = (slot_cnt == SLOT_CYCLES - 1);
    wire ms_tick = (ms_cnt == MS_CYCLES - 1);
    wire unit_tick = (unit_cnt == LOSS_UNIT_CYCLES - 1);
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_cnt <= 32'h0000_0000;
            ms_cnt <= 32'h0000_0000;
            unit_cnt <= 32'h0000_0000;
        end else begin
            slot_cnt <= slot_tick ? 32'h0000_0000 : slot_cnt + 32'h0000_0001;
            // A start command restarts the millisecond base so a reply delay is never cut short.
            ms_cnt <= (ms_tick || cmd_start) ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
            unit_cnt <= unit_tick ? 32'h0000_0000 : unit_cnt + 32'h0000_0001;
        end
    end

    // Receiver: samples mid-bit, checks start, parity and stop.
    reg rx_busy;
    reg [15:0] rx_cnt;
    reg [3:0] rx_bit;
    reg [7:0] rx_byte;
    reg rx_par;
    reg byte_done, byte_bad;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_busy <= 1'b0;
            rx_cnt <= 16'h0000;
            rx_bit <= 4'h0;
            rx_byte <= 8'h00;
            rx_par <= 1'b0;
            byte_done <= 1'b0;
            byte_bad <= 1'b0;
        end else begin
            byte_done <= 1'b0;
            if (!rx_busy) begin
                if (!rx_s2 && fieldbus_active) begin
                    rx_busy <= 1'b1;
                    rx_cnt <= baud_div >> 1;
                    rx_bit <= 4'h0;
                    byte_bad <= 1'b0;
                end
            end else if (rx_cnt != 16'h0000) begin
                rx_cnt <= rx_cnt - 16'h0001;
            end else begin
                rx_cnt <= baud_div - 16'h0001;
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0) begin
                    if (rx_s2) begin
                        rx_busy <= 1'b0;
                    end
                end else if (rx_bit <= 4'h8) begin
                    rx_byte <= {rx_s2, rx_byte[7:1]};
                end else if (rx_bit == 4'h9 && par_en) begin
                    rx_par <= rx_s2;
                end else begin
                    rx_busy <= 1'b0;
                    byte_done <= 1'b1;
                    byte_bad <= ~rx_s2 | (par_en & (rx_par != ((^rx_byte) ^ (parity == `PARITY_ODD))));
                end
            end
        end
    end

    // Frame capture, end-of-frame silence and address match.
    reg [7:0] rx_mem [0:DEPTH-1];
    reg [PTR_W:0] rx_len;
    reg [PTR_W-1:0] rx_rd;
    reg [23:0] idle_cnt;
    reg frame_err, frame_ready, rx_overflow, any_err;
    reg [15:0] req_regs, done_regs;
    reg proc_done;
    wire [7:0] fcode = rx_mem[1];
    wire multi = (fcode == 8'h03) || (fcode == 8'h04) || (fcode == 8'h10) || (fcode == 8'h17);
    wire [31:0] done_sum = {16'h0000, done_regs} + `SLOT_REGS;
    wire [16:0] done_next = done_sum[16:0];
    wire frame_end = (idle_cnt == t35_cyc) && (rx_len != 0) && !frame_ready;
    wire tx_finish;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_len <= {(PTR_W+1){1'b0}};
            idle_cnt <= 24'h00_0000;
            frame_err <= 1'b0;
            frame_ready <= 1'b0;
            rx_overflow <= 1'b0;
            any_err <= 1'b0;
            req_regs <= 16'h0000;
            done_regs <= 16'h0000;
            proc_done <= 1'b0;
        end else begin
            if (rx_busy || !rx_s2) begin
                idle_cnt <= 24'h00_0000;
            end else if (idle_cnt != t35_cyc) begin
                idle_cnt <= idle_cnt + 24'h00_0001;
            end
            if (byte_done && !frame_ready) begin
                if (rx_len < DEPTH) begin
                    rx_mem[rx_len[PTR_W-1:0]] <= rx_byte;
                    rx_len <= rx_len + 1'b1;
                end else begin
                    frame_err <= 1'b1;
                    rx_overflow <= 1'b1;
                end
                if (byte_bad) begin
                    frame_err <= 1'b1;
                    any_err <= 1'b1;
                end
            end
            if (frame_end) begin
                frame_err <= 1'b0;
                if (!frame_err && rx_len > 5 && rx_mem[0] == node_addr) begin
                    frame_ready <= 1'b1;
                    req_regs <= multi ? {rx_mem[4], rx_mem[5]} : 16'h0001;
                    done_regs <= 16'h0000;
                    proc_done <= 1'b0;
                end else begin
                    rx_len <= {(PTR_W+1){1'b0}};
                end
            end
            if (frame_ready && !proc_done && slot_tick) begin
                done_regs <= done_next[15:0];
                if (done_next >= {1'b0, req_regs}) begin
                    proc_done <= 1'b1;
                end
            end
            if (tx_finish || cmd_drop || !fieldbus_active) begin
                frame_ready <= 1'b0;
                proc_done <= 1'b0;
                rx_len <= {(PTR_W+1){1'b0}};
            end
        end
    end

    // Transmitter: waits the transmit delay, then drives the line byte by byte.
    localparam T_IDLE = 2'h0;
    localparam T_WAIT = 2'h1;
    localparam T_SEND = 2'h2;
    reg [1:0] t_state;
    reg [7:0] tx_mem [0:DEPTH-1];
    reg [PTR_W:0] tx_wr, tx_rd;
    reg [7:0] wait_ms;
    reg [15:0] tx_cnt;
    reg [3:0] tx_left;
    reg [11:0] tx_shift;
    reg tx_bit_on;
    wire [7:0] tx_byte = tx_mem[tx_rd[PTR_W-1:0]];
    wire tx_pbit = (^tx_byte) ^ (parity == `PARITY_ODD);
    assign tx_finish = (t_state == T_SEND) && !tx_bit_on && (tx_rd == tx_wr);
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            t_state <= T_IDLE;
            tx_wr <= {(PTR_W+1){1'b0}};
            tx_rd <= {(PTR_W+1){1'b0}};
            wait_ms <= 8'h00;
            tx_cnt <= 16'h0000;
            tx_left <= 4'h0;
            tx_shift <= 12'hFFF;
            tx_bit_on <= 1'b0;
            link_tx <= 1'b1;
            link_tx_oe <= 1'b0;
        end else begin
            if (wr_en && addr == `REG_TX_DATA && t_state == T_IDLE && tx_wr < DEPTH) begin
                tx_mem[tx_wr[PTR_W-1:0]] <= wr_data[7:0];
                tx_wr <= tx_wr + 1'b1;
            end
            case (t_state)
                T_IDLE: begin
                    link_tx <= 1'b1;
                    link_tx_oe <= 1'b0;
                    if (cmd_start && frame_ready && proc_done && fieldbus_active) begin
                        t_state <= T_WAIT;
                        wait_ms <= 8'h00;
                    end
                end
                T_WAIT: begin
                    if (wait_ms == tx_delay) begin
                        t_state <= T_SEND;
                        tx_rd <= {(PTR_W+1){1'b0}};
                        tx_bit_on <= 1'b0;
                    end else if (ms_tick) begin
                        wait_ms <= wait_ms + 8'h01;
                    end
                end
                T_SEND: begin
                    link_tx_oe <= 1'b1;
                    if (tx_bit_on) begin
                        if (tx_cnt != 16'h0000) begin
                            tx_cnt <= tx_cnt - 16'h0001;
                        end else if (tx_left == 4'h0) begin
                            tx_bit_on <= 1'b0;
                        end else begin
                            link_tx <= tx_shift[0];
                            tx_shift <= {1'b1, tx_shift[11:1]};
                            tx_left <= tx_left - 4'h1;
                            tx_cnt <= baud_div - 16'h0001;
                        end
                    end else if (tx_rd != tx_wr) begin
                        tx_bit_on <= 1'b1;
                        tx_cnt <= 16'h0000;
                        tx_left <= nbits + 4'h1;
                        tx_shift <= par_en ? {2'b11, tx_pbit, tx_byte, 1'b0} : {3'b111, tx_byte, 1'b0};
                        tx_rd <= tx_rd + 1'b1;
                    end else begin
                        t_state <= T_IDLE;
                        tx_wr <= {(PTR_W+1){1'b0}};
                        link_tx_oe <= 1'b0;
                    end
                end
                default: t_state <= T_IDLE;
            endcase
            if (!fieldbus_active) begin
                t_state <= T_IDLE;
                link_tx <= 1'b1;
                link_tx_oe <= 1'b0;
            end
        end
    end

    // Communication loss monitor.
    reg [8:0] loss_cnt;
    wire loss_restart = |(kick & cfg[`CFG_LOSS_SRC_HI:`CFG_LOSS_SRC_LO]);
    wire loss_hit = cfg[`CFG_LOSS_EN] && fieldbus_active && (loss_cnt > {1'b0, loss_time});
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            loss_cnt <= 9'h000;
            comm_loss <= 1'b0;
            comm_fault <= 1'b0;
            comm_warn <= 1'b0;
        end else begin
            if (loss_restart || !cfg[`CFG_LOSS_EN] || !fieldbus_active) begin
                loss_cnt <= 9'h000;
            end else if (unit_tick && loss_cnt != 9'h1FF) begin
                loss_cnt <= loss_cnt + 9'h001;
            end
            // A new loss in the clearing cycle keeps the flags set.
            if (loss_hit) begin
                comm_loss <= 1'b1;
                comm_fault <= comm_fault | (cfg[`CFG_ACTION_HI:`CFG_ACTION_LO] == `ACTION_FAULT);
                comm_warn <= comm_warn | (cfg[`CFG_ACTION_HI:`CFG_ACTION_LO] == `ACTION_WARN);
            end else if (cmd_clear) begin
                comm_loss <= 1'b0;
                comm_fault <= 1'b0;
                comm_warn <= 1'b0;
            end
        end
    end

    // Read port: data one cycle after the strobe; reading received data advances the pointer.
    wire rx_pop = rd_en && (addr == `REG_RX_DATA);
    wire rx_avail = frame_ready && ({1'b0, rx_rd} < rx_len);
    wire [15:0] word_lo = word32[15:0];
    wire [15:0] word_hi = word32[31:16];
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 32'h0000_0000;
            rx_rd <= {PTR_W{1'b0}};
        end else begin
            if (!frame_ready) begin
                rx_rd <= {PTR_W{1'b0}};
            end else if (rx_pop && rx_avail) begin
                rx_rd <= rx_rd + 1'b1;
            end
            rd_data <= 32'h0000_0000;
            if (rd_en) begin
                case (addr)
                    `REG_CONFIG: rd_data <= {21'h00_0000, cfg_stage};
                    `REG_NODE_ADDR: rd_data <= {24'h00_0000, node_stage};
                    `REG_BAUD_DIV: rd_data <= {16'h0000, div_stage};
                    `REG_LOSS_TIME: rd_data <= {24'h00_0000, loss_stage};
                    `REG_TX_DELAY: rd_data <= {24'h00_0000, delay_stage};
                    `REG_STATUS: rd_data <= {24'h00_0000, any_err, rx_overflow, t_state != T_IDLE,
                                             comm_loss, proc_done, frame_ready, panel_mode, fieldbus_active};
                    `REG_RX_DATA: rd_data <= {23'h00_0000, rx_avail, rx_mem[rx_rd]};
                    `REG_RX_COUNT: rd_data <= {{(31-PTR_W){1'b0}}, rx_len};
                    `REG_WORD32: rd_data <= word32;
                    `REG_WORD_FIRST: rd_data <= {16'h0000, cfg[`CFG_HI_WORD_FIRST] ? word_hi : word_lo};
                    `REG_WORD_SECOND: rd_data <= {16'h0000, cfg[`CFG_HI_WORD_FIRST] ? word_lo : word_hi};
                    default: rd_data <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // rtu_fieldbus_slave_port

// ===== rtu_fieldbus_slave_port_regs.vh
// Register offsets, field positions, reset values and timing counts of the RTU fieldbus slave port.
`ifndef RTU_FIELDBUS_SLAVE_PORT_REGS_VH
`define RTU_FIELDBUS_SLAVE_PORT_REGS_VH

`define ADDR_W 6
`define REG_CONFIG 6'h00
`define REG_NODE_ADDR 6'h04
`define REG_BAUD_DIV 6'h08
`define REG_LOSS_TIME 6'h0C
`define REG_TX_DELAY 6'h10
`define REG_COMMAND 6'h14
`define REG_STATUS 6'h18
`define REG_RX_DATA 6'h1C
`define REG_RX_COUNT 6'h20
`define REG_TX_DATA 6'h24
`define REG_WORD32 6'h28
`define REG_WORD_FIRST 6'h2C
`define REG_WORD_SECOND 6'h30

`define CFG_RTU_EN 0
`define CFG_LOSS_EN 1
`define CFG_LOSS_SRC_LO 2
`define CFG_LOSS_SRC_HI 4
`define CFG_HI_WORD_FIRST 5
`define CFG_PARITY_LO 6
`define CFG_PARITY_HI 7
`define CFG_TWO_STOP 8
`define CFG_ACTION_LO 9
`define CFG_ACTION_HI 10
`define CONFIG_RESET 11'h25E

`define CMD_REFRESH 0
`define CMD_KICK_LO 1
`define CMD_KICK_HI 3
`define CMD_START_REPLY 4
`define CMD_CLEAR_LOSS 5
`define CMD_DROP_FRAME 6

`define PARITY_NONE 2'h0
`define PARITY_EVEN 2'h1
`define PARITY_ODD 2'h2
`define ACTION_NONE 2'h0
`define ACTION_FAULT 2'h1
`define ACTION_WARN 2'h2

`define NODE_ADDR_RESET 8'h01
`define CLK_HZ 100000000
`define BAUD_RESET_BPS 19200
`define BAUD_DIV_RESET (`CLK_HZ / `BAUD_RESET_BPS)
`define LOSS_TIME_RESET 8'h1E
`define TX_DELAY_RESET 8'h00

`define SLOT_MS 10
`define SLOT_REGS 10
`define SLOT_CYCLES (`CLK_HZ / 1000 * `SLOT_MS)
`define MS_CYCLES (`CLK_HZ / 1000)
`define LOSS_UNIT_MS 100
`define LOSS_UNIT_CYCLES (`CLK_HZ / 1000 * `LOSS_UNIT_MS)

`endif

// ===== rtu_port_checker_asserts.sv
// Port-level checks of the RTU fieldbus slave port.
`timescale 1ns/1ps
`include "rtu_fieldbus_slave_port_regs.vh"
module rtu_port_checker (
    input wire sys_clk,
    input wire rst_n,
    input wire [`ADDR_W-1:0] addr,
    input wire [31:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    input wire [31:0] rd_data,
    input wire link_tx,
    input wire link_tx_oe,
    input wire panel_mode,
    input wire comm_loss,
    input wire comm_fault
);
    reg [2:0] since_rst;
    reg start_seen;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence reply_end;
        link_tx_oe ##1 !link_tx_oe;
    endsequence
    sequence status_read;
        rd_en && addr == `REG_STATUS;
    endsequence
    // The jumper is caught within four edges, so a saturated count marks a settled panel flag.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            since_rst <= 3'h0;
            start_seen <= 1'b0;
        end else begin
            if (since_rst != 3'h7)
                since_rst <= since_rst + 3'h1;
            if (wr_en && addr == `REG_COMMAND && wr_data[`CMD_START_REPLY])
                start_seen <= 1'b1;
        end
    end
    tx_idle_high_a: assert property (!link_tx_oe |-> link_tx) else $error("tx line low while not driven");
    reply_stop_a: assert property (reply_end |-> link_tx) else $error("reply ended off the stop level");
    panel_quiet_a: assert property (panel_mode |-> !link_tx_oe) else $error("driver on in panel mode");
    panel_hold_a: assert property (since_rst == 3'h7 |-> $stable(panel_mode)) else $error("panel flag moved");
    status_panel_a: assert property (status_read |=> rd_data[1] == panel_mode) else $error("status panel bit wrong");
    reply_gate_a: assert property (link_tx_oe |-> start_seen) else $error("reply sent without start");
    fault_has_loss_a: assert property (comm_fault |-> comm_loss) else $error("fault without loss");
    loss_sticky_a: assert property (comm_loss && !(wr_en && addr == `REG_COMMAND && wr_data[`CMD_CLEAR_LOSS])
        |=> comm_loss) else $error("loss flag dropped without clear");
endmodule // rtu_port_checker

// ===== rtu_master_model.sv
// Master station model: sends request frames and receives reply characters.
`timescale 1ns/1ps
module rtu_master_model (
    input wire sys_clk,
    input wire link_tx,
    input wire link_tx_oe,
    output reg link_rx
);
    initial link_rx = 1'b1;
    // One character: start, eight data bits LSB first, even parity, one stop.
    task send_byte(input [7:0] d, input integer div);
        reg [10:0] bits;
        integer i;
        begin
            bits = {1'b1, ^d, d, 1'b0};
            for (i = 0; i < 11; i = i + 1) begin
                link_rx <= bits[i];
                repeat (div) @(posedge sys_clk);
            end
        end
    endtask
    // Read request for twenty registers to one node; check bytes are left to software.
    task send_frame(input [7:0] node, input integer div);
        reg [63:0] f;
        integer i;
        begin
            f = {node, 8'h03, 16'h0000, 16'h0014, 16'h0000};
            for (i = 7; i >= 0; i = i - 1)
                send_byte(f[i*8+:8], div);
        end
    endtask
    task recv_byte(output [7:0] d, output ok, input integer div);
        reg [10:0] bits;
        integer i;
        begin
            for (i = 0; i < 1000 && !(link_tx_oe && !link_tx); i = i + 1)
                @(posedge sys_clk);
            repeat (div / 2) @(posedge sys_clk);
            for (i = 0; i < 11; i = i + 1) begin
                bits[i] = link_tx;
                repeat (div) @(posedge sys_clk);
            end
            d = bits[8:1];
            ok = !bits[0] && bits[9] == ^bits[8:1] && bits[10];
        end
    endtask
endmodule // rtu_master_model

// ===== test_rtu_fieldbus_slave_port.sv
// Self-checking bench for the RTU fieldbus slave port.
`timescale 1ns/1ps
`include "rtu_fieldbus_slave_port_regs.vh"
module test_rtu_fieldbus_slave_port;
    reg sys_clk = 1'b0;
    reg rst_n = 1'b0;
    reg [`ADDR_W-1:0] addr = 6'h00;
    reg [31:0] wr_data = 32'h0000_0000;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    reg jumper = 1'b0;
    wire [31:0] rd_data;
    wire link_rx, link_tx, link_tx_oe, panel_mode, comm_loss, comm_fault, comm_warn;
    integer num_errors = 0;
    integer checks_done = 0;
    integer n;
    reg [31:0] v;
    reg [7:0] b;
    reg ok;
    always #5 sys_clk = ~sys_clk;
    rtu_fieldbus_slave_port #(.SLOT_CYCLES(200), .MS_CYCLES(20), .LOSS_UNIT_CYCLES(50)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .link_rx(link_rx), .link_tx(link_tx), .link_tx_oe(link_tx_oe),
        .port_select_jumper(jumper), .panel_mode(panel_mode), .comm_loss(comm_loss),
        .comm_fault(comm_fault), .comm_warn(comm_warn));
    rtu_master_model master (.sys_clk(sys_clk), .link_tx(link_tx), .link_tx_oe(link_tx_oe), .link_rx(link_rx));
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", checks_done, num_errors);
            if (num_errors == 0 && checks_done > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task check(input [8*10-1:0] what, input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task bound(input integer lim);
        begin
            if (n >= lim) begin
                num_errors = num_errors + 1;
                report_and_stop;
            end
        end
    endtask
    task wr(input [5:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            addr <= a;
            wr_data <= d;
            wr_en <= 1'b1;
            @(posedge sys_clk);
            wr_en <= 1'b0;
        end
    endtask
    task rd(input [5:0] a, output [31:0] d);
        begin
            @(posedge sys_clk);
            addr <= a;
            rd_en <= 1'b1;
            @(posedge sys_clk);
            rd_en <= 1'b0;
            @(posedge sys_clk);
            d = rd_data;
        end
    endtask
    task rd_chk(input [5:0] a, input [31:0] exp, input [8*10-1:0] what);
        begin
            rd(a, v);
            check(what, v, exp);
        end
    endtask
    // Polls one status bit, counting elapsed cycles in n.
    task poll(input integer bit_i, input integer lim);
        begin
            v = 32'h0000_0000;
            for (n = 0; v[bit_i] !== 1'b1 && n < lim; n = n + 3)
                rd(`REG_STATUS, v);
            bound(lim);
        end
    endtask
    task frame_chk(input [7:0] node, input [2:0] exp, input [8*10-1:0] what);
        begin
            master.send_frame(node, 8);
            repeat (400) @(posedge sys_clk);
            rd(`REG_STATUS, v);
            check(what, v[2:0], exp);
        end
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd_chk(`REG_CONFIG, 32'h0000_025E, "config");
        rd_chk(`REG_NODE_ADDR, 32'h0000_0001, "node");
        rd_chk(`REG_BAUD_DIV, 32'h0000_1458, "baud_div");
        rd_chk(`REG_LOSS_TIME, 32'h0000_001E, "loss_time");
        rd_chk(`REG_TX_DELAY, 32'h0000_0000, "tx_delay");
        rd_chk(6'h3C, 32'h0000_0000, "unmapped");
        wr(`REG_BAUD_DIV, 32'h0000_0008);
        wr(`REG_TX_DELAY, 32'h0000_0002);
        wr(`REG_COMMAND, 32'h0000_0001);
        frame_chk(8'h01, 3'h0, "rtu_off");
        wr(`REG_CONFIG, 32'h0000_025F);
        frame_chk(8'h01, 3'h0, "staged");
        wr(`REG_COMMAND, 32'h0000_0001);
        frame_chk(8'h02, 3'h1, "other_node");
        master.send_frame(8'h01, 8);
        poll(2, 600);
        rd_chk(`REG_RX_COUNT, 32'h0000_0008, "rx_count");
        rd_chk(`REG_RX_DATA, 32'h0000_0101, "rx_byte0");
        poll(3, 600);
        check("slots", n >= 180 && n <= 440, 1);
        wr(`REG_TX_DATA, 32'h0000_00A5);
        wr(`REG_COMMAND, 32'h0000_0010);
        for (n = 0; link_tx_oe !== 1'b1 && n < 200; n = n + 1)
            @(posedge sys_clk);
        bound(200);
        check("tx_wait", n >= 40 && n <= 44, 1);
        master.recv_byte(b, ok, 8);
        check("reply", {ok, b}, 9'h1A5);
        wr(`REG_WORD32, 32'h1234_5678);
        rd_chk(`REG_WORD_FIRST, 32'h0000_5678, "lo_first");
        rd_chk(`REG_WORD_SECOND, 32'h0000_1234, "hi_second");
        wr(`REG_CONFIG, 32'h0000_027F);
        wr(`REG_COMMAND, 32'h0000_0001);
        rd_chk(`REG_WORD_FIRST, 32'h0000_1234, "hi_first");
        check("lost", comm_loss, 1);
        wr(`REG_COMMAND, 32'h0000_0002);
        wr(`REG_COMMAND, 32'h0000_0022);
        @(posedge sys_clk);
        check("cleared", comm_loss, 0);
        for (n = 1; n < 4; n = n + 1) begin
            repeat (1000) @(posedge sys_clk);
            wr(`REG_COMMAND, 32'h0000_0001 << n);
        end
        check("kicked", comm_loss, 0);
        for (n = 0; comm_loss !== 1'b1 && n < 2000; n = n + 1)
            @(posedge sys_clk);
        bound(2000);
        check("loss_time", n >= 1450 && n <= 1700, 1);
        check("fault", {comm_fault, comm_warn}, 2'h2);
        jumper <= 1'b1;
        rst_n <= 1'b0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check("panel", panel_mode, 1);
        rd(`REG_STATUS, v);
        check("panel_st", v[1:0], 2'h2);
        report_and_stop;
    end
endmodule // test_rtu_fieldbus_slave_port
bind rtu_fieldbus_slave_port rtu_port_checker checker_i (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .link_tx(link_tx),
    .link_tx_oe(link_tx_oe), .panel_mode(panel_mode), .comm_loss(comm_loss), .comm_fault(comm_fault));
